// file: hw/acw_pkg.sv
package acw_pkg;
    // Command word layout
    localparam int CMD_W = 16;
    localparam int SEL_BIT = 15;
    localparam int GRP_HI = 14;
    localparam int GRP_LO = 11;
    localparam int DATA_W = 11;
    localparam logic [3:0] GRP_CONFIG = 4'h0;
    localparam logic [3:0] GRP_UNIPOLAR = 4'h1;
    localparam logic [3:0] GRP_BIPOLAR = 4'h2;
    localparam logic [3:0] GRP_RANGE = 4'h3;
    localparam logic [3:0] GRP_SCAN_LIST_0 = 4'h4;
    localparam logic [3:0] GRP_SCAN_LIST_1 = 4'h5;
    localparam logic [3:0] GRP_SEQUENCE = 4'h6;
    localparam logic [3:0] GRP_RESERVED = 4'hF;
    localparam int NUM_CFG = 7;
    // Mode control fields
    localparam int SCAN_LO = 11;
    localparam int CHAN_HI = 10;
    localparam int CHAN_LO = 7;
    localparam int SRST_HI = 6;
    localparam int SRST_LO = 5;
    localparam int PM_HI = 4;
    localparam int PM_LO = 3;
    localparam int TAG_BIT = 2;
    localparam int TRIG_BIT = 1;
    localparam logic [3:0] SCAN_RST = 4'h1;
    localparam logic [3:0] SCAN_KEEP = 4'h0;
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic [1:0] PM_RST = 2'h0;
    localparam logic [1:0] SRST_NONE = 2'h0;
    localparam logic [1:0] SRST_FIFO = 2'h1;
    localparam logic [1:0] SRST_ALL = 2'h2;
    localparam logic [10:0] CFG_RST = 11'h000;
    // Link timing
    localparam int CORE_PERIOD_NS = 20;
    localparam int SCLK_PERIOD_NS = 160;
    localparam int SCLK_HALF = SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam int FRAME_SCLKS = 17;
    // Host register map
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RXDATA = 4'h8;
    localparam logic [3:0] OFS_CTRL = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/acw_link_if.sv
`timescale 1ns/1ps
interface acw_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic convert_start_pin_n;
    modport dev (input sclk, input cs_n, input din, input convert_start_pin_n, output dout);
    modport host (output sclk, output cs_n, output din, output convert_start_pin_n, input dout);
endinterface

// file: hw/acw_device_end.sv
// How it works
// - All register access arrives as serial command words
// - Bit 15 low loads mode control register
// - Bit 15 high targets a configuration register
// - Bits 14:11 pick register, low eleven stored
// - Host never sends reserved selection code; host end forwards it unchecked, device ignores it
// - Scan selection at 14:11, resets to 0001
// - Channel selection at 10:7, resets to 0000
// - Soft reset 01 clears FIFO only
// - Soft reset 10 restores all registers, clears FIFO
// - Power mode field at 4:3, resets 00
// - Tag bit gives channel then 12-bit result
// - Internal clock mode always tags output words
// - Trigger bit starts conversion on select rising, in internal clock mode only
// - Host rewrites trigger bit for each conversion
// - Trigger bit self-clears after conversion finishes
// - Host holds select low seventeen serial clocks
// - Scan code 0000 keeps scan, channel and tag bits
// - Host full-resets before leaving internal clock mode
`timescale 1ns/1ps
module acw_device_end
    import acw_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Serial link
    acw_link_if.dev link,
    // Converter core status
    input wire logic i_internal_clk_mode,
    input wire logic i_conv_done,
    input wire logic [11:0] i_result,
    input wire logic [3:0] i_result_chan,
    // Mode control fields
    output logic [3:0] o_scan_mode,
    output logic [3:0] o_input_channel_field,
    output logic [1:0] o_power_mode_field,
    output logic o_channel_tag_enable,
    output logic o_cs_edge_trigger,
    // Configuration registers
    output logic [NUM_CFG-1:0][DATA_W-1:0] o_cfg_regs,
    // Action pulses
    output logic o_fifo_clear,
    output logic o_conv_start
);

    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] din_sync;
    logic [1:0] cnv_sync;
    logic sclk_prev;
    logic cs_prev;
    logic cnv_prev;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic cnv_rise;
    logic [4:0] bit_cnt;
    logic [CMD_W-1:0] rx_shift;
    logic [CMD_W-1:0] cmd_word;
    logic cmd_stb;
    logic [CMD_W-1:0] tx_shift;
    logic [CMD_W-1:0] next_tx_load;
    logic mode_wr;
    logic cfg_wr;
    logic reset_all;
    logic [3:0] grp;

    // Two-flop synchronisers for every link pin
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            din_sync <= 2'h0;
            cnv_sync <= 2'h3;
        end else if (i_ce) begin
            sclk_sync <= {sclk_sync[0], link.sclk};
            cs_sync <= {cs_sync[0], link.cs_n};
            din_sync <= {din_sync[0], link.din};
            cnv_sync <= {cnv_sync[0], link.convert_start_pin_n};
        end
    end

    // Previous synchronised levels for edge finding
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
            cnv_prev <= 1'b1;
        end else if (i_ce) begin
            sclk_prev <= sclk_sync[1];
            cs_prev <= cs_sync[1];
            cnv_prev <= cnv_sync[1];
        end
    end

    // Edge events; serial clock edges gated by the select frame, select and start pin edges not
    assign sclk_rise = sclk_sync[1] & ~sclk_prev & ~cs_sync[1];
    assign sclk_fall = ~sclk_sync[1] & sclk_prev & ~cs_sync[1];
    assign cs_fall = ~cs_sync[1] & cs_prev;
    assign cs_rise = cs_sync[1] & ~cs_prev;
    assign cnv_rise = cnv_sync[1] & ~cnv_prev;

    // Command shift register, MSB first; extra edges in a frame are ignored
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            bit_cnt <= 5'h00;
            rx_shift <= 16'h0000;
            cmd_word <= 16'h0000;
            cmd_stb <= 1'b0;
        end else if (i_ce) begin
            cmd_stb <= 1'b0;
            if (cs_fall) begin
                bit_cnt <= 5'h00;
            end else if (sclk_rise && bit_cnt < 5'(CMD_W)) begin
                rx_shift <= {rx_shift[CMD_W-2:0], din_sync[1]};
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == 5'(CMD_W - 1)) begin
                    cmd_word <= {rx_shift[CMD_W-2:0], din_sync[1]};
                    cmd_stb <= 1'b1;
                end
            end
        end
    end

    // Word routing by selection bits
    assign grp = cmd_word[GRP_HI:GRP_LO];
    assign mode_wr = cmd_stb & ~cmd_word[SEL_BIT];
    assign cfg_wr = cmd_stb & cmd_word[SEL_BIT] & (grp != GRP_RESERVED);
    assign reset_all = mode_wr & (cmd_word[SRST_HI:SRST_LO] == SRST_ALL);

    // Scan, channel, power and tag fields of the mode register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_scan_mode <= SCAN_RST;
            o_input_channel_field <= CHAN_RST;
            o_power_mode_field <= PM_RST;
            o_channel_tag_enable <= 1'b0;
        end else if (i_ce) begin
            if (reset_all) begin
                o_scan_mode <= SCAN_RST;
                o_input_channel_field <= CHAN_RST;
                o_power_mode_field <= PM_RST;
                o_channel_tag_enable <= 1'b0;
            end else if (mode_wr) begin
                o_power_mode_field <= cmd_word[PM_HI:PM_LO];
                if (cmd_word[GRP_HI:SCAN_LO] != SCAN_KEEP) begin
                    o_scan_mode <= cmd_word[GRP_HI:SCAN_LO];
                    o_input_channel_field <= cmd_word[CHAN_HI:CHAN_LO];
                    o_channel_tag_enable <= cmd_word[TAG_BIT];
                end
            end
        end
    end

    // Trigger bit: a write wins over the completion clear
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_cs_edge_trigger <= 1'b0;
        end else if (i_ce) begin
            if (reset_all) begin
                o_cs_edge_trigger <= 1'b0;
            end else if (mode_wr) begin
                o_cs_edge_trigger <= cmd_word[TRIG_BIT];
            end else if (i_conv_done) begin
                o_cs_edge_trigger <= 1'b0;
            end
        end
    end

    // Configuration registers, one per selection code 0 to 6
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                o_cfg_regs[i] <= CFG_RST;
            end
        end else if (i_ce) begin
            if (reset_all) begin
                for (int i = 0; i < NUM_CFG; i++) begin
                    o_cfg_regs[i] <= CFG_RST;
                end
            end else if (cfg_wr && grp <= GRP_SEQUENCE) begin
                o_cfg_regs[grp[2:0]] <= cmd_word[DATA_W-1:0];
            end
        end
    end

    // FIFO clear pulse for soft reset codes 01 and 10
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_fifo_clear <= 1'b0;
        end else if (i_ce) begin
            o_fifo_clear <= mode_wr & ((cmd_word[SRST_HI:SRST_LO] == SRST_FIFO)
                | (cmd_word[SRST_HI:SRST_LO] == SRST_ALL));
        end
    end

    // Conversion start, in internal clock mode only, from select rising edge or from the start pin
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_conv_start <= 1'b0;
        end else if (i_ce) begin
            if (i_internal_clk_mode && o_cs_edge_trigger) begin
                o_conv_start <= cs_rise;
            end else begin
                o_conv_start <= i_internal_clk_mode & cnv_rise;
            end
        end
    end

    // Output word layout: tagged or plain result
    always_comb begin
        if (o_channel_tag_enable || i_internal_clk_mode) begin
            next_tx_load = {i_result_chan, i_result};
        end else begin
            next_tx_load = {i_result, 4'h0};
        end
    end

    // Result shifter, advanced on serial clock falling edges
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tx_shift <= 16'h0000;
            link.dout <= 1'b0;
        end else if (i_ce) begin
            if (cs_fall) begin
                tx_shift <= next_tx_load;
                link.dout <= next_tx_load[CMD_W-1];
            end else if (sclk_fall) begin
                tx_shift <= {tx_shift[CMD_W-2:0], 1'b0};
                link.dout <= tx_shift[CMD_W-2];
            end
        end
    end

endmodule // acw_device_end

// file: hw/acw_host_end.sv
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module acw_host_end
    import acw_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // AXI4-Lite write channels
    input wire logic [3:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read channels
    input wire logic [3:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Serial link
    acw_link_if.host link
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_TAIL = 2'b10,
        ST_GAP = 2'b11
    } acw_host_state_t;

    acw_host_state_t state;
    logic [3:0] aw_addr;
    logic aw_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_got;
    logic [CMD_W-1:0] cmd_reg;
    logic [CMD_W-1:0] tx_bits;
    logic [CMD_W-1:0] rx_reg;
    logic [4:0] sclk_cnt;
    logic [2:0] div;
    logic [1:0] dout_sync;
    logic start;
    logic do_write;

    assign do_write = aw_got & w_got & ~o_bvalid;
    assign start = do_write & (aw_addr == OFS_CMD) & (state == ST_IDLE) & w_strb[0];

    // Write address and data taken in either order
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
        end else if (i_ce) begin
            if (o_awready && i_awvalid) begin
                aw_addr <= i_awaddr;
                aw_got <= 1'b1;
                o_awready <= 1'b0;
            end
            if (o_wready && i_wvalid) begin
                w_data <= i_wdata;
                w_strb <= i_wstrb;
                w_got <= 1'b1;
                o_wready <= 1'b0;
            end
            if (o_bvalid && i_bready) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    // Write response; busy link, low strobe clear on command, or an offset other than command or control answers SLVERR
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            link.convert_start_pin_n <= 1'b1;
            cmd_reg <= 16'h0000;
        end else if (i_ce) begin
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end else if (do_write) begin
                o_bvalid <= 1'b1;
                o_bresp <= RESP_SLVERR;
                if (start) begin
                    cmd_reg <= w_data[CMD_W-1:0];
                    o_bresp <= RESP_OKAY;
                end else if (aw_addr == OFS_CTRL) begin
                    if (w_strb[0]) begin
                        link.convert_start_pin_n <= w_data[0];
                    end
                    o_bresp <= RESP_OKAY;
                end
            end
        end
    end

    // Read channel, one cycle answer
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= RESP_OKAY;
        end else if (i_ce) begin
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end else if (o_arready && i_arvalid) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rresp <= RESP_OKAY;
                unique case (i_araddr)
                    OFS_CMD: o_rdata <= {16'h0000, cmd_reg};
                    OFS_STATUS: o_rdata <= {31'h00000000, state != ST_IDLE};
                    OFS_RXDATA: o_rdata <= {16'h0000, rx_reg};
                    OFS_CTRL: o_rdata <= {31'h00000000, link.convert_start_pin_n};
                    default: begin
                        o_rdata <= 32'h00000000;
                        o_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Returned data synchroniser
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dout_sync <= 2'h0;
        end else if (i_ce) begin
            dout_sync <= {dout_sync[0], link.dout};
        end
    end

    // Frame engine: divides the core clock into the serial clock
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.din <= 1'b0;
            tx_bits <= 16'h0000;
            rx_reg <= 16'h0000;
            sclk_cnt <= 5'h00;
            div <= 3'h0;
        end else if (i_ce) begin
            div <= div + 3'h1;
            unique case (state)
                ST_IDLE: begin
                    div <= 3'h0;
                    if (start) begin
                        state <= ST_SHIFT;
                        link.cs_n <= 1'b0;
                        link.din <= w_data[CMD_W-1];
                        tx_bits <= {w_data[CMD_W-2:0], 1'b0};
                        sclk_cnt <= 5'h00;
                    end
                end
                ST_SHIFT: begin
                    if (div == 3'(SCLK_HALF - 1)) begin
                        div <= 3'h0;
                        link.sclk <= ~link.sclk;
                        // Returned bit taken at the fall: the sync path delays it past the rise
                        if (link.sclk) begin
                            if (sclk_cnt < 5'(CMD_W)) begin
                                rx_reg <= {rx_reg[CMD_W-2:0], dout_sync[1]};
                            end
                            sclk_cnt <= sclk_cnt + 5'h01;
                            link.din <= tx_bits[CMD_W-1];
                            tx_bits <= {tx_bits[CMD_W-2:0], 1'b0};
                            if (sclk_cnt == 5'(FRAME_SCLKS - 1)) begin
                                state <= ST_TAIL;
                            end
                        end
                    end
                end
                ST_TAIL: begin
                    if (div == 3'(SCLK_HALF - 1)) begin
                        div <= 3'h0;
                        link.cs_n <= 1'b1;
                        state <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (div == 3'(SCLK_HALF - 1)) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

endmodule // acw_host_end

// file: testbench/acw_link_properties.sv
`timescale 1ns/1ps
module acw_link_properties
    import acw_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic convert_start_pin_n,
    // Device side
    input wire logic i_internal_clk_mode,
    input wire logic i_conv_done,
    input wire logic o_cs_edge_trigger,
    input wire logic o_conv_start,
    input wire logic o_fifo_clear,
    input wire logic [1:0] o_power_mode_field
);
    logic [4:0] rise_cnt;
    logic [7:0] low_cnt;
    logic sclk_q;

    // Count core cycles and serial clock rises inside a frame
    always_ff @(posedge i_core_clk) begin
        if (i_rst || cs_n) begin
            rise_cnt <= 5'h00;
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= low_cnt + 8'h01;
            if (sclk && !sclk_q) begin
                rise_cnt <= rise_cnt + 5'h01;
            end
        end
    end

    // Previous serial clock level for edge finding
    always_ff @(posedge i_core_clk) begin
        sclk_q <= sclk;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // Steps of a frame
    sequence s_sclk_high;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence s_frame_end;
        $rose(cs_n);
    endsequence

    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock moved outside a frame");
    a_sclk_shape: assert property ($rose(sclk) |-> s_sclk_high)
        else $error("serial clock high phase has wrong length");
    a_din_steady: assert property (sclk |-> $stable(din))
        else $error("command bit changed while serial clock high");
    a_frame_clocks: assert property (s_frame_end |-> rise_cnt == 5'h11)
        else $error("frame did not carry seventeen serial clocks");
    a_frame_long: assert property (s_frame_end |-> low_cnt >= 8'h88)
        else $error("select held low too briefly");
    a_field_in_frame: assert property ($changed(o_power_mode_field) |-> !cs_n)
        else $error("power field changed outside a frame");
    a_edge_start: assert property (s_frame_end ##0 (o_cs_edge_trigger && i_internal_clk_mode)
        |-> ##[2:6] o_conv_start)
        else $error("select rise did not start a conversion");
    a_pin_start: assert property ($rose(convert_start_pin_n) && !o_cs_edge_trigger && i_internal_clk_mode
        |-> ##[2:6] o_conv_start)
        else $error("start pin did not start a conversion");
    a_trig_clear: assert property (i_conv_done |=> !o_cs_edge_trigger)
        else $error("trigger bit kept after conversion end");
    a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("conversion start longer than one cycle");
    a_clear_pulse: assert property (o_fifo_clear |=> !o_fifo_clear)
        else $error("buffer clear longer than one cycle");
endmodule // acw_link_properties

// file: testbench/adc_command_word_decoder_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t %s", $time, m); end end
module adc_command_word_decoder_tb_top
    import acw_pkg::*;
;
    logic i_core_clk, i_rst, int_mode, conv_done, cs_last, tag, trig, fclr, cstart;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr, wstrb, rchan, scan, chan, fifo_cnt, fifo_exp, m_scan, m_chan;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, pm, m_pm, e_b;
    logic [11:0] res;
    logic m_tag, m_trig;
    logic [NUM_CFG-1:0][DATA_W-1:0] cfg, m_cfg;
    logic [33:0] e_r;
    logic [92:0] e_d;
    logic [1:0] b_q[$];
    logic [33:0] r_q[$];
    logic [92:0] d_q[$];
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    acw_link_if link();
    acw_device_end acw_device_end_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(1'b1),
        .link(link), .i_internal_clk_mode(int_mode), .i_conv_done(conv_done), .i_result(res),
        .i_result_chan(rchan), .o_scan_mode(scan), .o_input_channel_field(chan),
        .o_power_mode_field(pm), .o_channel_tag_enable(tag), .o_cs_edge_trigger(trig),
        .o_cfg_regs(cfg), .o_fifo_clear(fclr), .o_conv_start(cstart));
    acw_host_end acw_host_end_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .link(link));
    acw_link_properties acw_link_properties_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din), .convert_start_pin_n(link.convert_start_pin_n),
        .i_internal_clk_mode(int_mode), .i_conv_done(conv_done), .o_cs_edge_trigger(trig),
        .o_conv_start(cstart), .o_fifo_clear(fclr), .o_power_mode_field(pm));

    // Core clock
    always #10 i_core_clk = ~i_core_clk;

    // Count buffer clear pulses and cut a hang short
    always @(posedge i_core_clk) begin
        cycles++;
        if (fclr === 1'b1) fifo_cnt <= fifo_cnt + 4'h1;
        if (cycles == 10000) begin
            num_errors++;
            end_sim();
        end
    end

    // Compare each result with the oldest note
    always @(negedge i_core_clk) begin
        if (bvalid && bready) begin
            e_b = b_q.pop_front();
            `CHK(bresp, e_b, "write response")
        end
        if (rvalid && rready) begin
            e_r = r_q.pop_front();
            `CHK({rresp, rdata}, e_r, "read data")
        end
        if (link.cs_n && !cs_last) begin
            e_d = d_q.pop_front();
            `CHK({scan, chan, pm, tag, trig, fifo_cnt, cfg}, e_d, "device fields")
        end
        cs_last = link.cs_n;
    end

    task automatic end_sim;
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] e);
        bit ta, tw, tb;
        b_q.push_back(e);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge i_core_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            @(posedge i_core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end while (!tb);
        @(posedge i_core_clk);
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
        bit ta, tr;
        r_q.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge i_core_clk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            @(posedge i_core_clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end while (!tr);
        @(posedge i_core_clk);
    endtask

    // Reference model of the mode control and configuration registers
    task automatic m_defaults;
        m_scan = SCAN_RST;
        m_chan = CHAN_RST;
        m_pm = PM_RST;
        m_tag = 1'b0;
        m_trig = 1'b0;
        m_cfg = {NUM_CFG{CFG_RST}};
    endtask

    task automatic apply(input logic [15:0] w);
        if (w[15]) begin
            if (w[14:11] < 4'h7) m_cfg[w[14:11]] = w[10:0];
        end else if (w[6:5] == SRST_ALL) begin
            m_defaults();
            fifo_exp++;
        end else begin
            if (w[6:5] == SRST_FIFO) fifo_exp++;
            m_pm = w[4:3];
            m_trig = w[1];
            if (w[14:11] != SCAN_KEEP) begin
                m_scan = w[14:11];
                m_chan = w[10:7];
                m_tag = w[2];
            end
        end
    endtask

    // One command frame, then the returned word and the idle status
    task automatic send(input logic [15:0] w, input bit poke);
        logic [11:0] r;
        logic [3:0] c;
        logic [15:0] ex;
        r = 12'($urandom);
        c = 4'($urandom);
        ex = (m_tag || int_mode) ? {c, r} : {r, 4'h0};
        res <= r;
        rchan <= c;
        axi_wr(OFS_CMD, {16'h0000, w}, 4'hF, RESP_OKAY);
        if (poke) axi_wr(OFS_CMD, 32'h0, 4'hF, RESP_SLVERR);
        apply(w);
        d_q.push_back({m_scan, m_chan, m_pm, m_tag, m_trig, fifo_exp, m_cfg});
        while (!link.cs_n) @(negedge i_core_clk);
        repeat (8) @(posedge i_core_clk);
        axi_rd(OFS_RXDATA, {RESP_OKAY, 16'h0000, ex});
        axi_rd(OFS_STATUS, {RESP_OKAY, 32'h0});
    endtask

    // Main sequence
    initial begin
        i_core_clk = 1'b0;
        i_rst = 1'b1;
        cs_last = 1'b1;
        fifo_cnt = 4'h0;
        fifo_exp = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready, int_mode, conv_done} = '0;
        {awaddr, araddr, wstrb, wdata, res, rchan} = '0;
        m_defaults();
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        void'($urandom(32'h1FB5));
        @(posedge i_core_clk);
        axi_rd(OFS_CTRL, {RESP_OKAY, 32'h1});
        for (int g = 0; g < 8; g++) begin
            send({1'b1, 4'(g), 11'($urandom)}, 1'b0);
        end
        send({5'h1F, 11'($urandom)}, 1'b1);
        for (int k = 0; k < 4; k++) begin
            send({1'b0, (k[0] ? SCAN_KEEP : 4'(k + 3)), 4'($urandom), 2'(k), 2'(k), ~k[0],
                2'h0}, 1'b0);
        end
        int_mode <= 1'b1;
        @(posedge i_core_clk);
        send({1'b0, 4'h3, 4'h5, SRST_NONE, 2'h1, 1'b0, 1'b1, 1'b0}, 1'b0);
        conv_done <= 1'b1;
        @(posedge i_core_clk);
        conv_done <= 1'b0;
        m_trig = 1'b0;
        axi_wr(OFS_CTRL, 32'h0, 4'hF, RESP_OKAY);
        axi_wr(OFS_CTRL, 32'h1, 4'hF, RESP_OKAY);
        send({1'b1, GRP_RANGE, 11'h7FF}, 1'b0);
        send({1'b0, SCAN_KEEP, 4'h0, SRST_ALL, 5'h00}, 1'b0);
        int_mode <= 1'b0;
        axi_wr(OFS_CMD, 32'h0, 4'hE, RESP_SLVERR);
        axi_wr(4'h6, 32'h0, 4'hF, RESP_SLVERR);
        axi_rd(4'h2, {RESP_SLVERR, 32'h0});
        axi_rd(OFS_CMD, {RESP_OKAY, 16'h0000, 1'b0, SCAN_KEEP, 4'h0, SRST_ALL, 5'h00});
        repeat (4) @(posedge i_core_clk);
        end_sim();
    end
endmodule // adc_command_word_decoder_tb_top
